// ==== pcrs_pkg.sv ====
package pcrs_pkg;
   localparam int PC_W        = 13;
   localparam int BYTE_W      = 8;
   localparam int LATCH_W     = 5;
   localparam int JUMP_W      = 11;
   localparam int STACK_DEPTH = 8;

   // Register offsets on the Avalon-MM port, word addresses
   localparam logic [1:0] OFS_PC_LOW     = 2'h0;
   localparam logic [1:0] OFS_PC_LATCH   = 2'h1;
   localparam logic [1:0] OFS_PC_STATUS  = 2'h2;

   localparam logic [PC_W-1:0]    PC_RESET    = 13'h0000;
   localparam logic [LATCH_W-1:0] LATCH_RESET = 5'h00;
   localparam logic [31:0]        UNMAPPED_RD = 32'h0000_0000;

   // Instruction sequencing commands from the decoder
   typedef enum logic [2:0]
   {
      PCRS_CMD_NEXT,
      PCRS_CMD_JUMP,
      PCRS_CMD_CALL,
      PCRS_CMD_RETURN,
      PCRS_CMD_VECTOR,
      PCRS_CMD_HOLD
   } pcrs_cmd_t;
endpackage

// ==== pcrs_core.sv ====
// How it works
// RULE1: A 13-bit program counter addresses the instruction being fetched.
// RULE2: Low byte of the counter is a readable, writable register.
// RULE3: Counter bits 12:8 never read back; written only via the latch.
// RULE4: Any reset clears the upper counter bits.
// RULE5: Writing the low byte loads bits 12:8 from latch bits 4:0.
// RULE6: Call or jump takes bits 12:11 from latch bits 4:3.
// RULE7: Software adding to the low byte must mind 256-word block edges.
// RULE8: Return stack holds eight 13-bit entries.
// RULE9: Stack and its pointer are invisible to software.
// RULE10: Calls and interrupt vectoring push the counter.
// RULE11: Return, return-with-literal and interrupt return pop the counter.
// RULE12: Pushes and pops leave the high latch unchanged.
// RULE13: Stack is circular; ninth push overwrites the first.
// RULE14: No overflow or underflow flag; wraparound is silent.
// RULE15: Stack moves only on calls, returns and vectoring.
// RULE16: Call and jump carry only an 11-bit target address.
// RULE17: A return restores all 13 bits from the stack entry.
// RULE18: A push saves the address that would have run next.
//
// The implementer's own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module pcrs_core
   import pcrs_pkg::*;
#(
   parameter int DEPTH = STACK_DEPTH
)
(
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic [1:0]        avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   input  wire logic [3:0]        avs_byteenable,
   output logic [31:0]            avs_readdata,
   output logic                   avs_waitrequest,
   input  wire logic [2:0]        cmd,
   input  wire logic [JUMP_W-1:0] jump_target,
   input  wire logic [PC_W-1:0]   vector_addr,
   output logic [PC_W-1:0]        pc
);
   localparam int PTR_W = $clog2(DEPTH);

   // Pointer wrap relies on a power-of-two depth
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
   begin : g_depth_check
      $error("DEPTH must be a power of two of at least two");
   end

   logic [PC_W-1:0]    pc_r;
   logic [PC_W-1:0]    pc_nxt;
   logic [LATCH_W-1:0] pc_high_latch_r;
   logic [PTR_W-1:0]   sp_r;
   logic [PC_W-1:0]    stack_r [DEPTH];
   logic               ack_r;
   logic [31:0]        rdata_r;
   logic [PC_W-1:0]    pc_inc;
   logic [PC_W-1:0]    top;
   logic               do_push;
   logic               do_pop;
   logic               acc;
   logic               wr_low;
   logic               wr_latch;
   pcrs_cmd_t          op;

   assign op      = pcrs_cmd_t'(cmd);
   assign pc      = pc_r; // RULE1
   assign pc_inc  = pc_r + 13'h0001;
   // RULE15
   assign do_push = (op == PCRS_CMD_CALL) || (op == PCRS_CMD_VECTOR); // RULE10
   assign do_pop  = (op == PCRS_CMD_RETURN); // RULE11
   assign top     = stack_r[sp_r - 1'b1];

   // One wait state per access; bus write lands on the acknowledging edge
   assign acc             = (avs_read || avs_write) && !ack_r;
   assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
   assign wr_low   = avs_write && ack_r && (avs_address == OFS_PC_LOW)
                     && avs_byteenable[0];
   assign wr_latch = avs_write && ack_r && (avs_address == OFS_PC_LATCH)
                     && avs_byteenable[0];

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         ack_r <= 1'b0;
      else
         ack_r <= acc;
   end

   // A low-byte write from software overrides the sequencer that cycle
   always_comb
   begin
      pc_nxt = pc_r;
      if (wr_low)
         pc_nxt = {pc_high_latch_r, avs_writedata[BYTE_W-1:0]}; // RULE5 RULE2
      else
      begin
         unique case (op)
            PCRS_CMD_NEXT:
               pc_nxt = pc_inc;
            PCRS_CMD_JUMP, PCRS_CMD_CALL:
               pc_nxt = {pc_high_latch_r[LATCH_W-1:LATCH_W-2],
                         jump_target}; // RULE6 RULE16
            PCRS_CMD_RETURN:
               pc_nxt = top; // RULE17
            PCRS_CMD_VECTOR:
               pc_nxt = vector_addr;
            PCRS_CMD_HOLD:
               pc_nxt = pc_r;
            default:
               pc_nxt = pc_r;
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         pc_r <= PC_RESET; // RULE4
      else
         pc_r <= pc_nxt;
   end

   // Latch only written by software; stack traffic never touches it
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         pc_high_latch_r <= LATCH_RESET;
      else if (wr_latch)
         pc_high_latch_r <= avs_writedata[LATCH_W-1:0]; // RULE12
   end

   // Pointer wraps freely, no flags kept
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         sp_r <= '0;
      else if (!wr_low && do_push)
         sp_r <= sp_r + 1'b1; // RULE13 RULE14
      else if (!wr_low && do_pop)
         sp_r <= sp_r - 1'b1; // RULE14
   end

   // Entries need no reset; stale values are what wrap exposes
   always_ff @(posedge ref_clk)
   begin
      if (rst_n && !wr_low && do_push)
         stack_r[sp_r] <= pc_inc; // RULE8 RULE18
   end

   // Stack pointer and upper counter bits are never mapped
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         rdata_r <= UNMAPPED_RD;
      else if (acc && avs_read)
      begin
         unique case (avs_address)
            OFS_PC_LOW:
               rdata_r <= {24'h000000, pc_r[BYTE_W-1:0]}; // RULE3 RULE9
            OFS_PC_LATCH:
               rdata_r <= {27'h0000000, pc_high_latch_r};
            default:
               rdata_r <= UNMAPPED_RD;
         endcase
      end
   end

   assign avs_readdata = rdata_r;
endmodule
`default_nettype wire

// ==== pcrs_dec.sv ====
`timescale 1ns/1ns
`default_nettype none
module pcrs_dec (
   input  wire logic       ref_clk,
   input  wire logic [2:0] op,
   output logic      [2:0] cmd
);
   always_ff @(posedge ref_clk)
      cmd <= op;
endmodule
`default_nettype wire

// ==== pcrs_core_props.sv ====
`timescale 1ns/1ns
`default_nettype none
module pcrs_core_props (
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic [1:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic [2:0]  cmd,
   input wire logic [12:0] pc
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Byte lanes unseen here, so any low write counts
   wire logic wr = avs_write && !avs_waitrequest && avs_address == 2'h0;
   wire logic rd = avs_read && !avs_waitrequest;
   sequence s_push; (cmd == 3'h2 || cmd == 3'h4) && !wr; endsequence
   sequence s_pop; cmd == 3'h3 && !wr; endsequence
   a_pc_step: assert property
      (cmd == 3'h0 && !wr |=> pc == $past(pc) + 13'h1) else $error("step");
   a_pc_hold: assert property
      (cmd == 3'h5 && !wr |=> $stable(pc)) else $error("hold");
   a_push_pop: assert property
      (s_push ##1 s_pop |=> pc == $past(pc, 2) + 13'h1) else $error("pop");
   a_reset_clear: assert property
      (disable iff (1'h0) !rst_n |=> pc == 13'h0) else $error("reset");
   a_wait_first: assert property
      ($rose(avs_read || avs_write) |-> avs_waitrequest) else $error("wait");
   a_wait_one: assert property
      (avs_waitrequest && avs_read |=> !avs_waitrequest) else $error("ack");
   a_read_high: assert property
      (rd |-> avs_readdata[31:8] == 24'h0) else $error("high");
   a_read_void: assert property
      (rd && avs_address[1] |-> avs_readdata == 32'h0) else $error("void");
endmodule
bind pcrs_core pcrs_core_props props (.*);
`default_nettype wire

// ==== program_counter_and_return_stack_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module program_counter_and_return_stack_tb;
   logic        ref_clk = 1'h0, rst_n = 1'h0, avs_read = 1'h0;
   logic        avs_write = 1'h0, avs_waitrequest;
   logic [1:0]  avs_address = 2'h0;
   logic [2:0]  op = 3'h5, cmd;
   logic [3:0]  avs_byteenable = 4'hf;
   logic [10:0] jump_target = 11'h0;
   logic [12:0] vector_addr = 13'h0abc, pc;
   logic [31:0] avs_writedata = 32'h0, avs_readdata;
   int          num_errors = 0, checks = 0;
   always #25 ref_clk = ~ref_clk;
   pcrs_core dut (.*);
   pcrs_dec dec (.*);
   task automatic chk(logic [31:0] g, e);
      checks++;
      num_errors += int'(g !== e);
      if (g !== e) $display("BAD %0t got %h want %h", $time, g, e);
   endtask
   task automatic bus(logic w, logic [1:0] a, logic [31:0] d, e);
      {avs_read, avs_write, avs_address, avs_writedata} <= {!w, w, a, d};
      do @(posedge ref_clk); while (avs_waitrequest);
      if (!w) chk(avs_readdata, e);
      {avs_read, avs_write} <= 2'h0;
      @(posedge ref_clk);
   endtask
   // Decoder adds a cycle, so pc settles two edges after issue
   task automatic run(logic [2:0] o, logic [10:0] t, logic [31:0] e);
      {op, jump_target} <= {o, t};
      @(posedge ref_clk);
      op <= 3'h5;
      repeat (2) @(posedge ref_clk);
      chk(pc, e);
   endtask
   task automatic tally_and_finish;
      if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      #100000 num_errors++;
      tally_and_finish;
   end
   initial
   begin
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'h1;
      bus(1'h1, 2'h1, 32'h1b, 32'h0);
      bus(1'h1, 2'h0, 32'h00, 32'h0);
      chk(pc, 32'h1b00);
      bus(1'h1, 2'h0, 32'h34, 32'h0);
      bus(1'h0, 2'h0, 32'h0, 32'h34);
      chk(pc, 32'h1b34);
      bus(1'h0, 2'h2, 32'h0, 32'h0);
      run(3'h1, 11'h155, 32'h1955);
      run(3'h0, 11'h0, 32'h1956);
      for (int k = 1; k < 10; k++) run(3'h2, 11'(k), 32'h1800 + k);
      for (int k = 9; k > 0; k--)
         run(3'h3, 11'h0, 32'h1800 + (k > 1 ? k : 9));
      avs_byteenable <= 4'h0;
      bus(1'h1, 2'h1, 32'h3, 32'h0);
      avs_byteenable <= 4'hf;
      bus(1'h0, 2'h1, 32'h0, 32'h1b);
      op <= 3'h4;
      @(posedge ref_clk);
      run(3'h3, 11'h0, 32'h180a);
      tally_and_finish;
   end
endmodule
`default_nettype wire
